// ==== core/rre_pkg.sv ====
package rre_pkg;
  localparam int PC_W     = 13;
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 8;
  localparam int STACK_D  = 8;
  localparam int SP_W     = 4;
  localparam int ROT_STEP = 1;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0] PC_RESET   = 13'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [SP_W-1:0]   SP_RESET  = 4'h0;

  typedef enum logic [2:0] {
    RRE_OP_NONE      = 3'h0,
    RRE_OP_RET       = 3'h1,
    RRE_OP_RET_IMM   = 3'h2,
    RRE_OP_INTERRUPT_EXIT      = 3'h3,
    RRE_OP_ROT_MEM   = 3'h4,
    RRE_OP_ROT_ACC   = 3'h5
  } rre_op_t;

  typedef enum logic [1:0] {
    RRE_ST_IDLE  = 2'b00,
    RRE_ST_READ  = 2'b01,
    RRE_ST_WRITE = 2'b11
  } rre_state_t;
endpackage : rre_pkg

// ==== core/rre_stack.sv ====
`timescale 1ns/10ps
module rre_stack
  import rre_pkg::*;
#(
  parameter int DEPTH = STACK_D
) (
  // clocking
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            ce,
  // control
  input  wire logic            push,
  input  wire logic [PC_W-1:0] push_pc,
  input  wire logic            pop,
  // status
  output logic      [PC_W-1:0] top_pc,
  output logic      [SP_W-1:0] sp
);
  logic [PC_W-1:0] mem_q [DEPTH];
  logic [SP_W-1:0] sp_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sp_q <= SP_RESET;
    end else if (ce) begin
      if (pop && sp_q != SP_RESET) begin
        sp_q <= sp_q - SP_W'(1);
      end else if (push && sp_q != SP_W'(DEPTH)) begin
        sp_q <= sp_q + SP_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce && push && !pop && sp_q != SP_W'(DEPTH)) begin
      mem_q[sp_q[SP_W-2:0]] <= push_pc;
    end
  end

  assign top_pc = (sp_q == SP_RESET) ? PC_RESET : mem_q[3'(sp_q - SP_W'(1))];
  assign sp     = sp_q;
endmodule : rre_stack

// ==== core/rre_exec.sv ====
`timescale 1ns/10ps
module rre_exec
  import rre_pkg::*;
(
  // clocking
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // instruction issue
  input  wire logic              issue,
  input  wire rre_op_t           op,
  input  wire logic [DATA_W-1:0] imm,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [PC_W-1:0]   call_pc,
  input  wire logic              call,
  input  wire logic              irq_pending,
  output logic                   busy,
  output logic                   done,
  // data memory port
  output logic      [ADDR_W-1:0] dm_addr,
  output logic                   dm_rd,
  output logic                   dm_wr,
  output logic      [DATA_W-1:0] dm_wdata,
  input  wire logic [DATA_W-1:0] dm_rdata,
  // core state
  output logic      [PC_W-1:0]   pc,
  output logic      [DATA_W-1:0] acc,
  output logic                   global_irq_enable,
  output logic      [SP_W-1:0]   stack_ptr
);
  rre_state_t        state_q;
  rre_op_t           op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [PC_W-1:0]   pc_q;
  logic [DATA_W-1:0] acc_q;
  logic              gie_q;
  logic              done_q;
  logic [PC_W-1:0]   top_pc;
  logic              is_ret;
  logic              take_irq;

  function automatic logic [DATA_W-1:0] rot_left(input logic [DATA_W-1:0] v);
    return {v[DATA_W-1-ROT_STEP:0], v[DATA_W-1:DATA_W-ROT_STEP]};
  endfunction : rot_left

  // return opcodes finish in the issue cycle
  function automatic logic ret_op(input rre_op_t o);
    return o == RRE_OP_RET || o == RRE_OP_RET_IMM || o == RRE_OP_INTERRUPT_EXIT;
  endfunction : ret_op

  // rotate opcodes pass through the read state
  function automatic logic rot_op(input rre_op_t o);
    return o == RRE_OP_ROT_MEM || o == RRE_OP_ROT_ACC;
  endfunction : rot_op

  assign is_ret   = issue && state_q == RRE_ST_IDLE && ret_op(op);
  // an interrupt already waiting is taken straight after an interrupt exit return
  assign take_irq = is_ret && op == RRE_OP_INTERRUPT_EXIT && irq_pending;

  // a chained interrupt neither pops nor pushes: the entry stays for the handler
  rre_stack u_stack (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .push    (call && !is_ret),
    .push_pc (call_pc),
    .pop     (is_ret && !take_irq),
    .top_pc  (top_pc),
    .sp      (stack_ptr)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= RRE_ST_IDLE;
      op_q    <= RRE_OP_NONE;
      addr_q  <= '0;
    end else if (ce) begin
      case (state_q)
        RRE_ST_IDLE: begin
          if (issue && rot_op(op)) begin
            state_q <= RRE_ST_READ;
            op_q    <= op;
            addr_q  <= mem_addr;
          end
        end
        RRE_ST_READ: begin
          state_q <= (op_q == RRE_OP_ROT_MEM) ? RRE_ST_WRITE : RRE_ST_IDLE;
        end
        RRE_ST_WRITE: begin
          state_q <= RRE_ST_IDLE;
        end
        default: state_q <= RRE_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdata_q <= '0;
    end else if (ce && state_q == RRE_ST_READ) begin
      wdata_q <= rot_left(dm_rdata);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_q <= PC_RESET;
    end else if (ce && is_ret) begin
      // stack entry is kept for the handler when an interrupt is chained
      pc_q <= take_irq ? IRQ_VECTOR : top_pc;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= ACC_RESET;
    end else if (ce) begin
      if (is_ret && op == RRE_OP_RET_IMM) begin
        acc_q <= imm;
      end else if (state_q == RRE_ST_READ && op_q == RRE_OP_ROT_ACC) begin
        acc_q <= rot_left(dm_rdata);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gie_q <= 1'b0;
    end else if (ce && is_ret && op == RRE_OP_INTERRUPT_EXIT) begin
      // handler entry clears enable again when chaining
      gie_q <= !take_irq;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= is_ret || (state_q == RRE_ST_READ && op_q == RRE_OP_ROT_ACC)
                || state_q == RRE_ST_WRITE;
    end
  end

  assign busy              = state_q != RRE_ST_IDLE;
  assign done              = done_q;
  assign dm_addr           = addr_q;
  assign dm_rd             = state_q == RRE_ST_READ;
  assign dm_wr             = state_q == RRE_ST_WRITE && op_q == RRE_OP_ROT_MEM;
  assign dm_wdata          = wdata_q;
  assign pc                = pc_q;
  assign acc               = acc_q;
  assign global_irq_enable = gie_q;

  AST_RET_PC: assert property (@(posedge clk) disable iff (!rst_n)
    ce && is_ret && op == RRE_OP_RET |=> pc == $past(top_pc))
    else $error("return did not reload pc");
  AST_RET_IMM: assert property (@(posedge clk) disable iff (!rst_n)
    ce && is_ret && op == RRE_OP_RET_IMM |=> acc == $past(imm))
    else $error("immediate not loaded");
  AST_INTERRUPT_EXIT_GIE: assert property (@(posedge clk) disable iff (!rst_n)
    ce && is_ret && op == RRE_OP_INTERRUPT_EXIT && !irq_pending |=> global_irq_enable)
    else $error("enable not set");
  AST_INTERRUPT_EXIT_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    ce && take_irq |=> pc == IRQ_VECTOR && stack_ptr == $past(stack_ptr))
    else $error("pending interrupt not vectored");
  AST_ROT_MEM: assert property (@(posedge clk) disable iff (!rst_n)
    ce && state_q == RRE_ST_READ && op_q == RRE_OP_ROT_MEM
    |=> dm_wr && dm_wdata == rot_left($past(dm_rdata)))
    else $error("rotate write wrong");
  AST_ROT_ACC: assert property (@(posedge clk) disable iff (!rst_n)
    ce && state_q == RRE_ST_READ && op_q == RRE_OP_ROT_ACC
    |=> acc == {$past(dm_rdata[6:0]), $past(dm_rdata[7])} && !dm_wr)
    else $error("rotate to acc wrong");
  AST_POP_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    ce && is_ret && !take_irq && stack_ptr != SP_RESET
    |=> stack_ptr == $past(stack_ptr) - SP_W'(1))
    else $error("pop count wrong");
  AST_NO_WR_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == RRE_ST_IDLE |-> !dm_wr && !dm_rd)
    else $error("stray memory access");
  AST_RET_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
    ce && is_ret && op == RRE_OP_RET
    |=> acc == $past(acc) && global_irq_enable == $past(global_irq_enable))
    else $error("plain return changed acc or enable");
  AST_RET_DONE: assert property (@(posedge clk) disable iff (!rst_n)
    ce && is_ret
    |=> done)
    else $error("return not signalled done");
  AST_IMM_GIE: assert property (@(posedge clk) disable iff (!rst_n)
    ce && is_ret && op == RRE_OP_RET_IMM
    |=> global_irq_enable == $past(global_irq_enable) && pc == $past(top_pc))
    else $error("return with immediate changed enable or pc");
  AST_INTERRUPT_EXIT_PC: assert property (@(posedge clk) disable iff (!rst_n)
    ce && is_ret && op == RRE_OP_INTERRUPT_EXIT && !irq_pending
    |=> pc == $past(top_pc))
    else $error("interrupt return did not reload pc");
  AST_IRQ_GIE: assert property (@(posedge clk) disable iff (!rst_n)
    ce && take_irq
    |=> !global_irq_enable)
    else $error("enable set while entering chained handler");
  AST_ROT_SAME: assert property (@(posedge clk) disable iff (!rst_n)
    ce && dm_rd && op_q == RRE_OP_ROT_MEM
    |=> dm_wr && dm_addr == $past(dm_addr))
    else $error("rotate written to another location");
  AST_ROT_PC: assert property (@(posedge clk) disable iff (!rst_n)
    ce && busy
    |=> pc == $past(pc) && global_irq_enable == $past(global_irq_enable))
    else $error("rotate changed pc or enable");
  AST_ROT_KEEP_ACC: assert property (@(posedge clk) disable iff (!rst_n)
    ce && busy && op_q == RRE_OP_ROT_MEM
    |=> acc == $past(acc))
    else $error("memory rotate changed acc");
  AST_ROT_ACC_DONE: assert property (@(posedge clk) disable iff (!rst_n)
    ce && dm_rd && op_q == RRE_OP_ROT_ACC
    |=> done && !busy)
    else $error("rotate to acc did not finish");
  AST_PUSH_TOP: assert property (@(posedge clk) disable iff (!rst_n)
    ce && call && !is_ret && stack_ptr != SP_W'(STACK_D)
    |=> stack_ptr == $past(stack_ptr) + SP_W'(1) && top_pc == $past(call_pc))
    else $error("call did not push into the freed entry");
  // clock enable low holds every register
  AST_CE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !ce
    |=> pc == $past(pc) && acc == $past(acc) && stack_ptr == $past(stack_ptr)
        && busy == $past(busy) && global_irq_enable == $past(global_irq_enable))
    else $error("state moved with clock enable low");
endmodule : rre_exec

// ==== verification/return_and_rotate_exec_tb.sv ====
`timescale 1ns/10ps
module return_and_rotate_exec_tb;
  import rre_pkg::*;
  logic              clk, rst_n, ce, issue, call, irq_pending;
  logic              busy, done, dm_rd, dm_wr, gie;
  rre_op_t           op;
  logic [DATA_W-1:0] imm, acc, dm_wdata, dm_rdata;
  logic [ADDR_W-1:0] mem_addr, dm_addr;
  logic [PC_W-1:0]   call_pc, pc;
  logic [SP_W-1:0]   sp;
  logic [DATA_W-1:0] mem [256];
  int                n_errors, n_compared, cyc;

  rre_exec DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .issue(issue), .op(op), .imm(imm),
    .mem_addr(mem_addr), .call_pc(call_pc), .call(call), .irq_pending(irq_pending),
    .busy(busy), .done(done), .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr),
    .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .pc(pc), .acc(acc),
    .global_irq_enable(gie), .stack_ptr(sp));

  // memory answers only in the read cycle, otherwise shows a changed value
  assign dm_rdata = dm_rd ? mem[dm_addr] : ~mem[dm_addr];
  always @(posedge clk) if (dm_wr) mem[dm_addr] <= dm_wdata;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic push(input logic [PC_W-1:0] v);
    @(negedge clk) call = 1'b1;
    call_pc = v;
    @(negedge clk) call = 1'b0;
  endtask : push

  task automatic ret(input rre_op_t o, input logic irq, input logic [PC_W-1:0] epc,
                     input logic [SP_W-1:0] esp, input logic eg, input logic [7:0] ea);
    @(negedge clk) issue = 1'b1;
    op = o;
    irq_pending = irq;
    @(negedge clk) issue = 1'b0;
    irq_pending = 1'b0;
    chk("done", 16'(done), 16'h0001);
    chk("pc", 16'(pc), 16'(epc));
    chk("sp", 16'(sp), 16'(esp));
    chk("gie", 16'(gie), 16'(eg));
    chk("acc", 16'(acc), 16'(ea));
    @(negedge clk);
    chk("done drop", 16'(done), 16'h0000);
  endtask : ret

  task automatic rot(input rre_op_t o, input logic [7:0] a, input int lat,
                     input logic [7:0] emem, input logic [7:0] ea);
    int k;
    @(negedge clk) issue = 1'b1;
    op = o;
    mem_addr = a;
    @(negedge clk) issue = 1'b0;
    chk("busy", 16'(busy), 16'h0001);
    k = 0;
    while (done !== 1'b1 && k < 6) begin
      @(negedge clk);
      k++;
    end
    chk("latency", 16'(k), 16'(lat - 1));
    @(negedge clk);
    chk("mem", 16'(mem[a]), 16'(emem));
    chk("acc", 16'(acc), 16'(ea));
    chk("busy end", 16'(busy), 16'h0000);
  endtask : rot

  task automatic freeze();
    @(negedge clk) ce = 1'b0;
    call = 1'b1;
    call_pc = 13'h0ABC;
    repeat (2) @(negedge clk);
    chk("sp frozen", 16'(sp), 16'h0000);
    chk("pc frozen", 16'(pc), 16'h0123);
    ce = 1'b1;
    @(negedge clk) call = 1'b0;
    chk("sp push", 16'(sp), 16'h0001);
    ret(RRE_OP_RET, 1'b0, 13'h0ABC, 4'h0, 1'b1, 8'h9C);
  endtask : freeze

  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  initial begin
    {rst_n, issue, call, irq_pending} = 4'h0;
    ce = 1'b1;
    op = RRE_OP_NONE;
    imm = 8'hA5;
    mem_addr = 8'h00;
    call_pc = 13'h0000;
    n_errors = 0;
    n_compared = 0;
    cyc = 0;
    mem[8'h3C] = 8'h81;
    mem[8'hC5] = 8'h4E;
    repeat (16) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    chk("pc reset", 16'(pc), 16'(PC_RESET));
    chk("sp reset", 16'(sp), 16'(SP_RESET));
    push(13'h0123);
    push(13'h0456);
    push(13'h0789);
    ret(RRE_OP_RET, 1'b0, 13'h0789, 4'h2, 1'b0, 8'h00);
    ret(RRE_OP_RET_IMM, 1'b0, 13'h0456, 4'h1, 1'b0, 8'hA5);
    ret(RRE_OP_INTERRUPT_EXIT, 1'b1, IRQ_VECTOR, 4'h1, 1'b0, 8'hA5);
    ret(RRE_OP_INTERRUPT_EXIT, 1'b0, 13'h0123, 4'h0, 1'b1, 8'hA5);
    rot(RRE_OP_ROT_MEM, 8'h3C, 3, 8'h03, 8'hA5);
    rot(RRE_OP_ROT_ACC, 8'hC5, 2, 8'h4E, 8'h9C);
    chk("pc after rot", 16'(pc), 16'h0123);
    freeze();
    complete_run();
  end
endmodule : return_and_rotate_exec_tb
